/* File: shared/ppm_consts.vh */
// Register addresses, pages and reset values for the port mode and latch block
`ifndef PPM_CONSTS_VH
`define PPM_CONSTS_VH

`define PPM_PAGE_F          8'h0f
`define PPM_ADDR_P1_LATCH   8'h90
`define PPM_ADDR_P2_LATCH   8'ha0
`define PPM_ADDR_P3_LATCH   8'hb0
`define PPM_ADDR_P4_LATCH   8'hc8
`define PPM_ADDR_P5_LATCH   8'hd8
`define PPM_ADDR_P6_LATCH   8'he8
`define PPM_ADDR_P7_LATCH   8'hf8
`define PPM_ADDR_P1_DRV     8'ha5
`define PPM_ADDR_P2_DRV     8'ha6
`define PPM_ADDR_P3_DRV     8'ha7
`define PPM_ADDR_P4_DRV     8'h9c
`define PPM_ADDR_P5_DRV     8'h9d
`define PPM_ADDR_P6_DRV     8'h9e
`define PPM_ADDR_P7_DRV     8'h9f
`define PPM_ADDR_P1_INSEL   8'had

`define PPM_LATCH_RESET     8'hff
`define PPM_DRV_RESET       8'h00
`define PPM_INSEL_RESET     8'hff
`define PPM_UNMAPPED_READ   8'h00

`define PPM_NUM_PORTS       7
`define PPM_PORT_W          8

`endif

/* File: logic/ppm_pin_cell.v */
// One port pin: driver source, driver type and weak pull-up control
`default_nettype none

module ppm_pin_cell (
  input  wire sys_clk,
  input  wire reset,
  input  wire latch_val,
  input  wire push_pull,
  input  wire port_enable,
  input  wire xbar_own,
  input  wire xbar_val,
  input  wire xbar_force_od,
  input  wire external_memory_iface_own,
  input  wire external_memory_iface_val,
  input  wire external_memory_iface_drive,
  input  wire digital_in,
  input  wire pullup_global_disable,
  output reg  pin_out,
  output reg  pin_oe,
  output reg  pin_pullup_en
);

  reg src_val;
  reg open_drain;
  reg drive;

  always @*
  begin
    // Memory interface wins over crossbar and latch; latch itself is untouched
    if (external_memory_iface_own)
      src_val = external_memory_iface_val;
    else if (xbar_own)
      src_val = xbar_val;
    else
      src_val = latch_val;
    open_drain = ~push_pull | (xbar_own & ~external_memory_iface_own & xbar_force_od);
    if (external_memory_iface_own)
      drive = external_memory_iface_drive & (~src_val | ~open_drain);
    else
      drive = port_enable & (~src_val | ~open_drain);
  end

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pin_out       <= 1'b1;
      pin_oe        <= 1'b0;
      pin_pullup_en <= 1'b1;
    end
    else
    begin
      pin_out       <= src_val;
      pin_oe        <= drive;
      // Pull-up off when driving low, so it never fights its own driver
      pin_pullup_en <= digital_in & ~pullup_global_disable & ~(drive & ~src_val);
    end
  end

endmodule

`default_nettype wire

/* File: logic/ppm_port_block.v */
// Port latches, driver selection and readback for ports 1 to 7, input selection for port 1
`default_nettype none
`include "ppm_consts.vh"

module ppm_port_block #(
  parameter NUM_PORTS = `PPM_NUM_PORTS,
  parameter PORT_W    = `PPM_PORT_W
) (
  input  wire                        sys_clk,
  input  wire                        reset,
  input  wire [7:0]                  sfr_addr,
  input  wire [7:0]                  sfr_page,
  input  wire                        sfr_wr,
  input  wire [7:0]                  sfr_wdata,
  input  wire                        sfr_bit_wr,
  input  wire [2:0]                  sfr_bit_sel,
  input  wire                        sfr_bit_val,
  input  wire                        sfr_rd,
  input  wire                        sfr_rmw,
  input  wire [NUM_PORTS*PORT_W-1:0] pin_in,
  input  wire                        xbar_enable,
  input  wire [NUM_PORTS*PORT_W-1:0] xbar_own,
  input  wire [NUM_PORTS*PORT_W-1:0] xbar_val,
  input  wire [NUM_PORTS*PORT_W-1:0] xbar_force_od,
  input  wire                        pullup_global_disable,
  input  wire                        external_memory_iface_active,
  input  wire                        external_memory_iface_mux_mode,
  input  wire                        external_memory_iface_addr_phase,
  input  wire [7:0]                  external_memory_iface_addr_hi,
  input  wire [7:0]                  external_memory_iface_addr_lo,
  input  wire [7:0]                  external_memory_iface_data_out,
  input  wire                        external_memory_iface_data_oe,
  output reg  [7:0]                  sfr_rdata,
  output reg                         sfr_hit,
  output wire [NUM_PORTS*PORT_W-1:0] pin_out,
  output wire [NUM_PORTS*PORT_W-1:0] pin_oe,
  output wire [NUM_PORTS*PORT_W-1:0] pin_pullup_en
);

  localparam NPIN = NUM_PORTS * PORT_W;

  // Decoded target, one-hot kind
  localparam KIND_NONE  = 3'b000;
  localparam KIND_LATCH = 3'b001;
  localparam KIND_DRV   = 3'b010;
  localparam KIND_INSEL = 3'b100;

  reg  [NPIN-1:0]   latch_reg;
  reg  [NPIN-1:0]   drv_reg;
  reg  [PORT_W-1:0] insel_reg;

  reg  [2:0]        sel_kind;
  reg  [2:0]        sel_port;
  wire              page_f;

  reg  [7:0]        sfr_rdata_next;
  reg               sfr_hit_next;

  wire [NPIN-1:0]   digital_in;
  wire [NPIN-1:0]   pin_view;
  wire [NPIN-1:0]   external_memory_iface_own;
  wire [NPIN-1:0]   external_memory_iface_val;
  wire [NPIN-1:0]   external_memory_iface_drive;
  wire [NPIN-1:0]   port_enable;
  wire [NPIN-1:0]   xbar_take;
  wire [7:0]        external_memory_iface_p2_val;
  wire [7:0]        external_memory_iface_p3_val;
  wire [7:0]        bit_mask;

  assign page_f = (sfr_page == `PPM_PAGE_F);

  // Address decode; ports 1-3 latches ignore the page
  always @*
  begin
    sel_kind = KIND_NONE;
    sel_port = 3'd0;
    if (sfr_addr == `PPM_ADDR_P1_LATCH)
    begin
      sel_kind = KIND_LATCH;
      sel_port = 3'd1;
    end
    else if (sfr_addr == `PPM_ADDR_P2_LATCH)
    begin
      sel_kind = KIND_LATCH;
      sel_port = 3'd2;
    end
    else if (sfr_addr == `PPM_ADDR_P3_LATCH)
    begin
      sel_kind = KIND_LATCH;
      sel_port = 3'd3;
    end
    else if (!page_f)
    begin
      sel_kind = KIND_NONE;
      sel_port = 3'd0;
    end
    else if (sfr_addr == `PPM_ADDR_P4_LATCH)
    begin
      sel_kind = KIND_LATCH;
      sel_port = 3'd4;
    end
    else if (sfr_addr == `PPM_ADDR_P5_LATCH)
    begin
      sel_kind = KIND_LATCH;
      sel_port = 3'd5;
    end
    else if (sfr_addr == `PPM_ADDR_P6_LATCH)
    begin
      sel_kind = KIND_LATCH;
      sel_port = 3'd6;
    end
    else if (sfr_addr == `PPM_ADDR_P7_LATCH)
    begin
      sel_kind = KIND_LATCH;
      sel_port = 3'd7;
    end
    else if (sfr_addr == `PPM_ADDR_P1_DRV)
    begin
      sel_kind = KIND_DRV;
      sel_port = 3'd1;
    end
    else if (sfr_addr == `PPM_ADDR_P2_DRV)
    begin
      sel_kind = KIND_DRV;
      sel_port = 3'd2;
    end
    else if (sfr_addr == `PPM_ADDR_P3_DRV)
    begin
      sel_kind = KIND_DRV;
      sel_port = 3'd3;
    end
    else if (sfr_addr == `PPM_ADDR_P4_DRV)
    begin
      sel_kind = KIND_DRV;
      sel_port = 3'd4;
    end
    else if (sfr_addr == `PPM_ADDR_P5_DRV)
    begin
      sel_kind = KIND_DRV;
      sel_port = 3'd5;
    end
    else if (sfr_addr == `PPM_ADDR_P6_DRV)
    begin
      sel_kind = KIND_DRV;
      sel_port = 3'd6;
    end
    else if (sfr_addr == `PPM_ADDR_P7_DRV)
    begin
      sel_kind = KIND_DRV;
      sel_port = 3'd7;
    end
    else if (sfr_addr == `PPM_ADDR_P1_INSEL)
    begin
      sel_kind = KIND_INSEL;
      sel_port = 3'd1;
    end
  end

  assign bit_mask = 8'h01 << sfr_bit_sel;

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p = p + 1)
    begin : g_port
      wire hit_latch;
      wire hit_drv;

      assign hit_latch = (sel_kind == KIND_LATCH) && (sel_port == p + 1);
      assign hit_drv   = (sel_kind == KIND_DRV) && (sel_port == p + 1);

      // Latch holds its value through memory interface cycles
      always @(posedge sys_clk or posedge reset)
      begin
        if (reset)
          latch_reg[p*PORT_W +: PORT_W] <= `PPM_LATCH_RESET;
        else if (sfr_wr && hit_latch)
          latch_reg[p*PORT_W +: PORT_W] <= sfr_wdata;
        // Byte write wins over a bit write in the same cycle
        else if (sfr_bit_wr && hit_latch)
          latch_reg[p*PORT_W +: PORT_W] <=
            (latch_reg[p*PORT_W +: PORT_W] & ~bit_mask) |
            (sfr_bit_val ? bit_mask : 8'h00);
      end

      // Driver selects clear to open-drain at reset
      always @(posedge sys_clk or posedge reset)
      begin
        if (reset)
          drv_reg[p*PORT_W +: PORT_W] <= `PPM_DRV_RESET;
        else if (sfr_wr && hit_drv)
          drv_reg[p*PORT_W +: PORT_W] <= sfr_wdata;
      end
    end
  endgenerate

  // Resets to digital so port 1 reads its pins from the start
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      insel_reg <= `PPM_INSEL_RESET;
    else if (sfr_wr && (sel_kind == KIND_INSEL))
      insel_reg <= sfr_wdata;
  end

  // Memory interface values for the second and third ports
  assign external_memory_iface_p2_val = external_memory_iface_mux_mode ? external_memory_iface_addr_hi : external_memory_iface_addr_lo;
  assign external_memory_iface_p3_val = (external_memory_iface_mux_mode && external_memory_iface_addr_phase) ? external_memory_iface_addr_lo : external_memory_iface_data_out;

  genvar i;
  generate
    for (i = 0; i < NPIN; i = i + 1)
    begin : g_pin
      if (i < PORT_W)
      begin : g_p1
        assign digital_in[i]  = insel_reg[i];
        assign external_memory_iface_own[i]    = 1'b0;
        assign external_memory_iface_val[i]    = 1'b1;
        assign external_memory_iface_drive[i]  = 1'b0;
        assign port_enable[i] = xbar_enable;
        assign xbar_take[i]   = xbar_own[i] & xbar_enable;
      end
      else if (i < 2*PORT_W)
      begin : g_p2
        assign digital_in[i]  = 1'b1;
        assign external_memory_iface_own[i]    = external_memory_iface_active;
        assign external_memory_iface_val[i]    = external_memory_iface_p2_val[i-PORT_W];
        assign external_memory_iface_drive[i]  = 1'b1;
        assign port_enable[i] = xbar_enable;
        assign xbar_take[i]   = xbar_own[i] & xbar_enable;
      end
      else if (i < 3*PORT_W)
      begin : g_p3
        assign digital_in[i]  = 1'b1;
        assign external_memory_iface_own[i]    = external_memory_iface_active;
        assign external_memory_iface_val[i]    = external_memory_iface_p3_val[i-2*PORT_W];
        // Read cycles release the data bus drivers, except in the multiplexed address phase
        assign external_memory_iface_drive[i]  = external_memory_iface_data_oe | (external_memory_iface_mux_mode & external_memory_iface_addr_phase);
        assign port_enable[i] = xbar_enable;
        assign xbar_take[i]   = xbar_own[i] & xbar_enable;
      end
      else
      begin : g_hi
        assign digital_in[i]  = 1'b1;
        assign external_memory_iface_own[i]    = 1'b0;
        assign external_memory_iface_val[i]    = 1'b1;
        assign external_memory_iface_drive[i]  = 1'b0;
        assign port_enable[i] = 1'b1;
        // No crossbar reaches the upper ports
        assign xbar_take[i]   = 1'b0;
      end

      // Analog pins read zero; a read-modify-write still sees the latch
      assign pin_view[i] = pin_in[i] & digital_in[i];

      ppm_pin_cell u_cell (
        .sys_clk               (sys_clk),
        .reset                 (reset),
        .latch_val             (latch_reg[i]),
        .push_pull             (drv_reg[i]),
        .port_enable           (port_enable[i]),
        .xbar_own              (xbar_take[i]),
        .xbar_val              (xbar_val[i]),
        .xbar_force_od         (xbar_force_od[i]),
        .external_memory_iface_own              (external_memory_iface_own[i]),
        .external_memory_iface_val              (external_memory_iface_val[i]),
        .external_memory_iface_drive            (external_memory_iface_drive[i]),
        .digital_in            (digital_in[i]),
        .pullup_global_disable (pullup_global_disable),
        .pin_out               (pin_out[i]),
        .pin_oe                (pin_oe[i]),
        .pin_pullup_en         (pin_pullup_en[i])
      );
    end
  endgenerate

  // Read path; result appears one cycle after the strobe
  // A read in a write cycle returns the value before the write
  always @*
  begin
    sfr_rdata_next = `PPM_UNMAPPED_READ;
    sfr_hit_next   = 1'b0;
    if (!sfr_rd)
    begin
      sfr_rdata_next = `PPM_UNMAPPED_READ;
      sfr_hit_next   = 1'b0;
    end
    else if (sel_kind == KIND_LATCH)
    begin
      sfr_hit_next = 1'b1;
      if (sfr_rmw)
        sfr_rdata_next = latch_reg[(sel_port-3'd1)*PORT_W +: PORT_W];
      else
        sfr_rdata_next = pin_view[(sel_port-3'd1)*PORT_W +: PORT_W];
    end
    else if (sel_kind == KIND_DRV)
    begin
      sfr_hit_next   = 1'b1;
      sfr_rdata_next = drv_reg[(sel_port-3'd1)*PORT_W +: PORT_W];
    end
    else if (sel_kind == KIND_INSEL)
    begin
      sfr_hit_next   = 1'b1;
      sfr_rdata_next = insel_reg;
    end
  end

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      sfr_rdata <= `PPM_UNMAPPED_READ;
      sfr_hit   <= 1'b0;
    end
    else
    begin
      sfr_rdata <= sfr_rdata_next;
      sfr_hit   <= sfr_hit_next;
    end
  end

endmodule

`default_nettype wire

/* File: sim/ppm_pin_model.sv */
// Board-side model of the port pins
`default_nettype none
module ppm_pin_model (
  input  wire logic        sys_clk,
  input  wire logic [55:0] pin_out,
  input  wire logic [55:0] pin_oe,
  input  wire logic [55:0] pin_pullup_en,
  input  wire logic [55:0] ext_drive,
  input  wire logic [55:0] ext_val,
  output logic      [55:0] pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [55:0] flt = '0;
  // Floating pins wander each cycle so a stale level never passes
  always @(posedge sys_clk)
    flt <= ~flt;
  always_comb
    pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive & ext_val)
      | (~pin_oe & ~ext_drive & (pin_pullup_en | flt));
endmodule
`default_nettype wire

/* File: sim/ppm_port_block_checker.sv */
// Concurrent checks on register reads and pin outputs
`default_nettype none
module ppm_port_block_checker (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic [7:0]  sfr_addr,
  input wire logic [7:0]  sfr_page,
  input wire logic        sfr_rd,
  input wire logic        sfr_rmw,
  input wire logic        pullup_global_disable,
  input wire logic        external_memory_iface_active,
  input wire logic        external_memory_iface_mux_mode,
  input wire logic        external_memory_iface_addr_phase,
  input wire logic        external_memory_iface_data_oe,
  input wire logic [7:0]  external_memory_iface_addr_hi,
  input wire logic [7:0]  external_memory_iface_addr_lo,
  input wire logic [55:0] pin_in,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        sfr_hit,
  input wire logic [55:0] pin_out,
  input wire logic [55:0] pin_oe,
  input wire logic [55:0] pin_pullup_en
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  chk_page_refuse: assert property (
    sfr_rd && sfr_addr == 8'ha6 && sfr_page != 8'h0f |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("page-only register answered off page");
  chk_p2_pins: assert property (
    sfr_rd && !sfr_rmw && sfr_addr == 8'ha0 |=> sfr_hit && sfr_rdata == $past(pin_in[15:8]))
    else $error("second port read not pin levels");
  chk_rdata_stands: assert property (
    !sfr_rd |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("read answer without read");
  chk_pull_low: assert property (
    (pin_pullup_en & pin_oe & ~pin_out) == 56'h0)
    else $error("pull-up on pin driving low");
  chk_pull_global: assert property (
    pullup_global_disable |=> pin_pullup_en == 56'h0)
    else $error("pull-up on while disabled");
  chk_external_memory_iface_mux: assert property (
    external_memory_iface_active && external_memory_iface_mux_mode |=> (pin_oe[15:8] | pin_out[15:8]) == 8'hff
      && pin_out[15:8] == $past(external_memory_iface_addr_hi))
    else $error("multiplexed high address missing");
  chk_external_memory_iface_nonmux: assert property (
    external_memory_iface_active && !external_memory_iface_mux_mode |=> (pin_oe[15:8] | pin_out[15:8]) == 8'hff
      && pin_out[15:8] == $past(external_memory_iface_addr_lo))
    else $error("non-multiplexed low address missing");
  chk_external_memory_iface_read: assert property (
    external_memory_iface_active && !external_memory_iface_data_oe && !(external_memory_iface_mux_mode && external_memory_iface_addr_phase) |=> pin_oe[23:16] == 8'h00)
    else $error("data bus driven during read");
endmodule
bind ppm_port_block ppm_port_block_checker chk (.sys_clk, .reset, .sfr_addr, .sfr_page, .sfr_rd,
  .sfr_rmw, .pullup_global_disable, .external_memory_iface_active, .external_memory_iface_mux_mode, .external_memory_iface_addr_phase, .external_memory_iface_data_oe,
  .external_memory_iface_addr_hi, .external_memory_iface_addr_lo, .pin_in, .sfr_rdata, .sfr_hit, .pin_out, .pin_oe, .pin_pullup_en);
`default_nettype wire

/* File: sim/ppm_port_block_bench.sv */
// Self-checking bench for the port mode and latch block
`default_nettype none
module ppm_port_block_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 0, reset = 1, sfr_wr = 0, sfr_bit_wr = 0, sfr_bit_val = 0, sfr_rd = 0;
  logic sfr_rmw = 0, xbar_enable = 0, pullup_global_disable = 0, external_memory_iface_active = 0;
  logic external_memory_iface_mux_mode = 0, external_memory_iface_addr_phase = 0, external_memory_iface_data_oe = 0, sfr_hit;
  logic [2:0] sfr_bit_sel = 0;
  logic [7:0] sfr_addr = 0, sfr_page = 0, sfr_wdata = 0, sfr_rdata;
  logic [7:0] external_memory_iface_addr_hi = 0, external_memory_iface_addr_lo = 0, external_memory_iface_data_out = 0;
  logic [55:0] xbar_own = 0, xbar_val = 0, xbar_force_od = 0, ext_drive = 0, ext_val = 0;
  logic [55:0] pin_in, pin_out, pin_oe, pin_pullup_en;
  int mismatches = 0, n_compared = 0, cyc = 0;
  ppm_port_block dut (.sys_clk, .reset, .sfr_addr, .sfr_page, .sfr_wr, .sfr_wdata, .sfr_bit_wr,
    .sfr_bit_sel, .sfr_bit_val, .sfr_rd, .sfr_rmw, .pin_in, .xbar_enable, .xbar_own, .xbar_val,
    .xbar_force_od, .pullup_global_disable, .external_memory_iface_active, .external_memory_iface_mux_mode, .external_memory_iface_addr_phase,
    .external_memory_iface_addr_hi, .external_memory_iface_addr_lo, .external_memory_iface_data_out, .external_memory_iface_data_oe, .sfr_rdata, .sfr_hit, .pin_out,
    .pin_oe, .pin_pullup_en);
  ppm_pin_model pins (.sys_clk, .pin_out, .pin_oe, .pin_pullup_en, .ext_drive, .ext_val, .pin_in);
  initial
    forever #2.5 sys_clk = ~sys_clk;
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Strobe then one idle edge, so pins have settled on return
  task automatic wr(input logic [7:0] a, pg, d, input logic b = 0);
    {sfr_addr, sfr_page, sfr_wdata, sfr_bit_sel, sfr_bit_val} = {a, pg, d, d[2:0], d[3]};
    {sfr_wr, sfr_bit_wr} = {!b, b};
    tick();
    {sfr_wr, sfr_bit_wr} = 2'b00;
    tick();
  endtask
  task automatic rd(input logic [7:0] a, pg, input logic m, input logic [8:0] exp);
    {sfr_addr, sfr_page, sfr_rmw, sfr_rd} = {a, pg, m, 1'b1};
    tick();
    check({sfr_hit, sfr_rdata}, exp);
    {sfr_rd, sfr_rmw} = 2'b00;
    tick();
  endtask
  task automatic external_memory_iface(input logic [3:0] m, input logic [31:0] exp);
    {external_memory_iface_active, external_memory_iface_mux_mode, external_memory_iface_addr_phase, external_memory_iface_data_oe} = m;
    tick();
    tick();
    check({pin_oe[23:8], pin_out[23:8]}, exp);
  endtask
  initial
  begin
    repeat (10) @(posedge sys_clk);
    #1 reset = 0;
    for (int i = 0; i < 3; i++)
      rd(8'ha5 + i, 8'h0f, 0, 9'h100);
    rd(8'hb0, 8'h03, 1, 9'h1ff);
    rd(8'had, 8'h0f, 0, 9'h1ff);
    wr(8'hb0, 8'h00, 8'h00);
    check(pin_oe[23:16], 8'h00);
    rd(8'hb0, 8'h00, 0, 9'h1ff);
    rd(8'hb0, 8'h00, 1, 9'h100);
    wr(8'hb0, 8'h00, 8'hff);
    check(pin_oe, 56'h0);
    check(pin_pullup_en, {56{1'b1}});
    $display("test reset values done");
    xbar_enable = 1;
    wr(8'ha0, 8'h00, 8'h5a);
    wr(8'ha6, 8'h0f, 8'h0f);
    wr(8'ha6, 8'h00, 8'hff);
    check({pin_oe[15:8], pin_out[15:8], pin_pullup_en[15:8]}, 24'haf5a5a);
    rd(8'ha6, 8'h00, 0, 9'h000);
    rd(8'ha6, 8'h0f, 0, 9'h10f);
    ext_drive[14] = 1;
    rd(8'ha0, 8'h05, 0, 9'h11a);
    rd(8'ha0, 8'h05, 1, 9'h15a);
    ext_drive = '0;
    {xbar_own[8], xbar_val[8], xbar_force_od[8]} = 3'b111;
    tick();
    tick();
    check({pin_oe[8], pin_out[8]}, 2'b01);
    xbar_force_od[8] = 0;
    tick();
    tick();
    check({pin_oe[8], pin_out[8]}, 2'b11);
    xbar_own = '0;
    $display("test driver modes done");
    wr(8'had, 8'h0f, 8'hf0);
    check(pin_pullup_en[7:0], 8'hf0);
    rd(8'h90, 8'h00, 0, 9'h1f0);
    rd(8'h90, 8'h00, 1, 9'h1ff);
    $display("test input select done");
    wr(8'hc8, 8'h0f, 8'h03, 1);
    rd(8'hc8, 8'h0f, 1, 9'h1f7);
    check({pin_oe[31:24], pin_out[31:24]}, 16'h08f7);
    wr(8'h9c, 8'h0f, 8'h81);
    check({pin_oe[31:24], pin_out[31:24]}, 16'h89f7);
    rd(8'hc8, 8'h0f, 0, 9'h1f7);
    rd(8'hc8, 8'h00, 0, 9'h000);
    rd(8'h55, 8'h0f, 0, 9'h000);
    wr(8'hd8, 8'h0f, 8'h00);
    rd(8'hd8, 8'h0f, 1, 9'h100);
    $display("test upper ports done");
    pullup_global_disable = 1;
    tick();
    tick();
    check(pin_pullup_en, 56'h0);
    pullup_global_disable = 0;
    {external_memory_iface_addr_hi, external_memory_iface_addr_lo, external_memory_iface_data_out} = 24'h3cc399;
    external_memory_iface(4'b1110, 32'h3ccf_c33c);
    external_memory_iface(4'b1101, 32'h66cf_993c);
    external_memory_iface(4'b1001, 32'h663f_99c3);
    external_memory_iface_data_oe = 0;
    tick();
    tick();
    check(pin_oe[23:16], 8'h00);
    external_memory_iface(4'b0000, 32'h00af_ff5a);
    rd(8'ha0, 8'h00, 1, 9'h15a);
    $display("test memory interface done");
    reset = 1;
    tick();
    reset = 0;
    rd(8'ha6, 8'h0f, 0, 9'h100);
    $display("test second reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
